/* src/sfd_pkg.sv */
// Shared constants, types and carriers for the serial FIFO data path
package sfd_pkg;

    // FIFO geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL_COUNT = 5'h10;

    // Register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned REG_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_RX_DATA = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_TX_DATA = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MODE = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

    // Format/mode register layout and reset value
    localparam logic [REG_W-1:0] MODE_RESET = 16'h0000;
    localparam logic [REG_W-1:0] MODE_WRITE_MASK = 16'h00ff;
    localparam int unsigned MODE_SYNC_BIT = 7;

    // Status register layout
    localparam int unsigned STAT_RX_CNT_LSB = 0;
    localparam int unsigned STAT_TX_CNT_LSB = 5;
    localparam int unsigned STAT_TX_BUSY_BIT = 10;

    // Value returned for an empty receive FIFO or a write-only location
    localparam logic [DATA_W-1:0] EMPTY_READ_VALUE = 8'h00;
    localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;

    // Character framing
    localparam logic [3:0] LAST_BIT_INDEX = 4'h7;
    localparam logic [3:0] FIRST_SYNC_INDEX = 4'h1;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL = 1'b1;

    typedef enum logic [1:0] {
        SFD_LS_IDLE = 2'b00,
        SFD_LS_DATA = 2'b01,
        SFD_LS_STOP = 2'b10
    } sfd_line_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
    } sfd_reg_req_s;

endpackage

/* src/sfd_sync.sv */
// Two flip-flop level synchroniser with a reset value
`timescale 1ns/10ps
module sfd_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* src/sfd_fifo.sv */
// Sixteen entry byte FIFO with honest full and empty
`timescale 1ns/10ps
module sfd_fifo
    import sfd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic push_valid_i,
    output logic push_ready_o,
    input wire logic [sfd_pkg::DATA_W-1:0] push_data_i,
    output logic pop_valid_o,
    input wire logic pop_ready_i,
    output logic [sfd_pkg::DATA_W-1:0] pop_data_o,
    output logic [sfd_pkg::CNT_W-1:0] count_o
);
    logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic do_push;
    logic do_pop;

    // A push into a full FIFO is dropped and leaves the contents alone
    assign push_ready_o = (count_q != FIFO_FULL_COUNT);
    assign pop_valid_o = (count_q != '0);
    assign do_push = push_valid_i && push_ready_o;
    assign do_pop = pop_ready_i && pop_valid_o;
    assign pop_data_o = mem_q[rd_ptr_q];
    assign count_o = count_q;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 4'h1;
            end
            case ({do_push, do_pop})
                2'b10: count_q <= count_q + 5'h01;
                2'b01: count_q <= count_q - 5'h01;
                default: count_q <= count_q;
            endcase
        end
    end
endmodule

/* src/sfd_top.sv */
// Serial FIFO data path: register port, FIFOs, link-side shift registers
`timescale 1ns/10ps
//
// Overview of operation
// - Receiver shifts serial input in, LSB first
// - Completed receive byte moves into receive FIFO
// - Shift registers are hidden from the CPU
// - Receive FIFO holds sixteen bytes of eight bits
// - Back-to-back bytes accepted until sixteen held
// - Byte arriving at full receive FIFO is dropped
// - CPU writes to receive FIFO have no effect
// - Empty receive FIFO read returns unspecified value
// - Idle transmitter loads oldest FIFO byte, starts
// - Transmitter drives each byte LSB first
// - Transmitter keeps going until FIFO is empty
// - Transmit FIFO holds sixteen bytes of eight bits
// - Write to full transmit FIFO is dropped
// - Transmit FIFO write-only, writable at any time
// - Mode register sixteen bits, readable, resets zero
// - Mode bits fifteen to eight read zero
// - Mode bit seven selects asynchronous or synchronous
// - Synchronous characters are always eight bits
module sfd_top
    import sfd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire sfd_pkg::sfd_reg_req_s reg_req_i,
    output logic [sfd_pkg::REG_W-1:0] reg_rdata_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o
);
    import sfd_pkg::*;

    // Core domain
    logic [REG_W-1:0] format_mode_reg_q;
    logic [REG_W-1:0] rdata_q;

    logic wr_rx;
    logic wr_tx;
    logic wr_mode;
    logic rd_rx;

    logic rx_push_ready;
    logic rx_pop_valid;
    logic [DATA_W-1:0] rx_pop_data;
    logic [CNT_W-1:0] rx_count;
    logic rx_pop;

    logic tx_push_ready;
    logic tx_pop_valid;
    logic [DATA_W-1:0] tx_pop_data;
    logic [CNT_W-1:0] tx_count;
    logic tx_pop;

    logic rx_tgl_s;
    logic rx_tgl_seen_q;
    logic rx_arrive;

    logic [DATA_W-1:0] tx_hold_q;
    logic tx_load_tgl_q;
    logic tx_busy_q;
    logic tx_done_s;
    logic tx_done_seen_q;
    logic tx_done_edge;

    // Link domain
    logic link_rst_b;
    logic mode_sync_l;
    logic rxd_s;
    logic ld_tgl_s;
    logic ld_seen_q;
    logic ld_edge;

    sfd_line_e rx_state_q;
    logic [3:0] rx_cnt_q;
    logic [DATA_W-1:0] rx_shift_reg_q;
    logic [DATA_W-1:0] rx_next;
    logic [DATA_W-1:0] rx_hold_q;
    logic rx_tgl_q;

    sfd_line_e tx_state_q;
    logic [3:0] tx_cnt_q;
    logic [DATA_W-1:0] tx_shift_reg_q;
    logic serial_out_q;
    logic tx_done_tgl_q;

    // Address decode; the shift registers have no address at all
    assign wr_rx = reg_req_i.wr && (reg_req_i.addr == OFS_RX_DATA);
    assign wr_tx = reg_req_i.wr && (reg_req_i.addr == OFS_TX_DATA);
    assign wr_mode = reg_req_i.wr && (reg_req_i.addr == OFS_MODE);
    assign rd_rx = reg_req_i.rd && (reg_req_i.addr == OFS_RX_DATA);

    // A write to the receive data offset is decoded only to be ignored
    assign rx_pop = rd_rx && rx_pop_valid;

    sfd_fifo u_rx_fifo (
        .clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .push_valid_i(rx_arrive),
        .push_ready_o(rx_push_ready),
        .push_data_i(rx_hold_q),
        .pop_valid_o(rx_pop_valid),
        .pop_ready_i(rx_pop),
        .pop_data_o(rx_pop_data),
        .count_o(rx_count)
    );

    sfd_fifo u_tx_fifo (
        .clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .push_valid_i(wr_tx),
        .push_ready_o(tx_push_ready),
        .push_data_i(reg_req_i.wdata[DATA_W-1:0]),
        .pop_valid_o(tx_pop_valid),
        .pop_ready_i(tx_pop),
        .pop_data_o(tx_pop_data),
        .count_o(tx_count)
    );

    // Mode register; upper byte never stores anything
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            format_mode_reg_q <= MODE_RESET;
        end else if (wr_mode) begin
            format_mode_reg_q <= reg_req_i.wdata & MODE_WRITE_MASK;
        end
    end

    // Read data stand for exactly the cycle after the read strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rdata_q <= REG_ZERO;
        end else if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                OFS_RX_DATA: begin
                    if (rx_pop_valid) begin
                        rdata_q <= {8'h00, rx_pop_data};
                    end else begin
                        rdata_q <= {8'h00, EMPTY_READ_VALUE};
                    end
                end
                OFS_MODE: rdata_q <= format_mode_reg_q;
                OFS_STATUS: begin
                    rdata_q <= REG_ZERO;
                    rdata_q[STAT_RX_CNT_LSB +: CNT_W] <= rx_count;
                    rdata_q[STAT_TX_CNT_LSB +: CNT_W] <= tx_count;
                    rdata_q[STAT_TX_BUSY_BIT] <= tx_busy_q;
                end
                // Transmit data is write-only and reads as zero
                default: rdata_q <= REG_ZERO;
            endcase
        end else begin
            rdata_q <= REG_ZERO;
        end
    end

    assign reg_rdata_o = rdata_q;

    // Receive byte handover: link toggles, core sees the edge two flops later
    sfd_sync u_rx_tgl_sync (
        .clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(rx_tgl_q),
        .q_o(rx_tgl_s)
    );

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rx_tgl_seen_q <= 1'b0;
        end else begin
            rx_tgl_seen_q <= rx_tgl_s;
        end
    end

    // The held receive byte is stable for a whole character after each toggle
    assign rx_arrive = rx_tgl_s ^ rx_tgl_seen_q;

    // Transmit handover: pop only while the link shifter is known empty
    assign tx_pop = tx_pop_valid && !tx_busy_q;

    sfd_sync u_tx_done_sync (
        .clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(tx_done_tgl_q),
        .q_o(tx_done_s)
    );

    assign tx_done_edge = tx_done_s ^ tx_done_seen_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            tx_done_seen_q <= 1'b0;
        end else begin
            tx_done_seen_q <= tx_done_s;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            tx_hold_q <= 8'h00;
            tx_load_tgl_q <= 1'b0;
            tx_busy_q <= 1'b0;
        end else if (tx_pop) begin
            tx_hold_q <= tx_pop_data;
            tx_load_tgl_q <= !tx_load_tgl_q;
            tx_busy_q <= 1'b1;
        end else if (tx_done_edge) begin
            tx_busy_q <= 1'b0;
        end
    end

    // Link-side logic
    // Link reset follows the core reset through a synchroniser
    sfd_sync u_link_rst_sync (
        .clk_i(link_clk_i),
        .rst_b_i(1'b1),
        .d_i(rst_b_i),
        .q_o(link_rst_b)
    );

    sfd_sync u_mode_sync (
        .clk_i(link_clk_i),
        .rst_b_i(link_rst_b),
        .d_i(format_mode_reg_q[MODE_SYNC_BIT]),
        .q_o(mode_sync_l)
    );

    // Idle line level at reset so a reset is not taken for a start bit
    sfd_sync #(.W(1), .RST_VAL(1'b1)) u_rxd_sync (
        .clk_i(link_clk_i),
        .rst_b_i(link_rst_b),
        .d_i(serial_in_pin_i),
        .q_o(rxd_s)
    );

    sfd_sync u_ld_sync (
        .clk_i(link_clk_i),
        .rst_b_i(link_rst_b),
        .d_i(tx_load_tgl_q),
        .q_o(ld_tgl_s)
    );

    assign ld_edge = ld_tgl_s ^ ld_seen_q;

    // Newest bit enters at the top, so the first bit ends in bit 0
    assign rx_next = {rxd_s, rx_shift_reg_q[DATA_W-1:1]};

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_b) begin
            rx_state_q <= SFD_LS_IDLE;
            rx_cnt_q <= CNT_ZERO;
            rx_shift_reg_q <= 8'h00;
            rx_hold_q <= 8'h00;
            rx_tgl_q <= 1'b0;
        end else begin
            case (rx_state_q)
                SFD_LS_IDLE: begin
                    if (mode_sync_l) begin
                        // Synchronous: every clock carries a data bit
                        rx_shift_reg_q <= rx_next;
                        rx_cnt_q <= FIRST_SYNC_INDEX;
                        rx_state_q <= SFD_LS_DATA;
                    end else if (rxd_s == START_LEVEL) begin
                        rx_cnt_q <= CNT_ZERO;
                        rx_state_q <= SFD_LS_DATA;
                    end
                end
                SFD_LS_DATA: begin
                    rx_shift_reg_q <= rx_next;
                    if (rx_cnt_q == LAST_BIT_INDEX) begin
                        if (mode_sync_l) begin
                            rx_hold_q <= rx_next;
                            rx_tgl_q <= !rx_tgl_q;
                            rx_state_q <= SFD_LS_IDLE;
                        end else begin
                            rx_state_q <= SFD_LS_STOP;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                    end
                end
                SFD_LS_STOP: begin
                    // A framing fault on the stop bit discards the character
                    if (rxd_s == STOP_LEVEL) begin
                        rx_hold_q <= rx_shift_reg_q;
                        rx_tgl_q <= !rx_tgl_q;
                    end
                    rx_state_q <= SFD_LS_IDLE;
                end
                default: rx_state_q <= SFD_LS_IDLE;
            endcase
        end
    end

    // Transmit shifter; tx_hold_q is stable whenever ld_edge is seen
    always_ff @(posedge link_clk_i) begin
        if (!link_rst_b) begin
            tx_state_q <= SFD_LS_IDLE;
            tx_cnt_q <= CNT_ZERO;
            tx_shift_reg_q <= 8'h00;
            serial_out_q <= LINE_IDLE;
            tx_done_tgl_q <= 1'b0;
            ld_seen_q <= 1'b0;
        end else begin
            case (tx_state_q)
                SFD_LS_IDLE: begin
                    serial_out_q <= LINE_IDLE;
                    if (ld_edge) begin
                        ld_seen_q <= ld_tgl_s;
                        tx_state_q <= SFD_LS_DATA;
                        if (mode_sync_l) begin
                            serial_out_q <= tx_hold_q[0];
                            tx_shift_reg_q <= {1'b0, tx_hold_q[DATA_W-1:1]};
                            tx_cnt_q <= FIRST_SYNC_INDEX;
                        end else begin
                            serial_out_q <= START_LEVEL;
                            tx_shift_reg_q <= tx_hold_q;
                            tx_cnt_q <= CNT_ZERO;
                        end
                    end
                end
                SFD_LS_DATA: begin
                    serial_out_q <= tx_shift_reg_q[0];
                    tx_shift_reg_q <= {1'b0, tx_shift_reg_q[DATA_W-1:1]};
                    if (tx_cnt_q == LAST_BIT_INDEX) begin
                        if (mode_sync_l) begin
                            tx_done_tgl_q <= !tx_done_tgl_q;
                            tx_state_q <= SFD_LS_IDLE;
                        end else begin
                            tx_state_q <= SFD_LS_STOP;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                    end
                end
                SFD_LS_STOP: begin
                    serial_out_q <= STOP_LEVEL;
                    tx_done_tgl_q <= !tx_done_tgl_q;
                    tx_state_q <= SFD_LS_IDLE;
                end
                default: tx_state_q <= SFD_LS_IDLE;
            endcase
        end
    end

    assign serial_out_pin_o = serial_out_q;

    // Drops at a full FIFO are silent; the ready terms and wr_rx drive nothing, status reports the two counts and tx_busy_q only
    logic unused_ready;
    assign unused_ready = rx_push_ready ^ tx_push_ready ^ wr_rx;

endmodule

/* tb/sfd_top_sva.sv */
// Concurrent checks on the serial FIFO data path ports
`timescale 1ns/10ps
module sfd_top_sva
    import sfd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire sfd_pkg::sfd_reg_req_s reg_req_i,
    input wire logic [sfd_pkg::REG_W-1:0] reg_rdata_o,
    input wire logic serial_in_pin_i,
    input wire logic serial_out_pin_o
);
    logic [REG_W-1:0] mode_q;
    logic [3:0] frame_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            mode_q <= MODE_RESET;
        end else if (reg_req_i.wr && reg_req_i.addr == OFS_MODE) begin
            mode_q <= reg_req_i.wdata & MODE_WRITE_MASK;
        end
    end
    // Mode only changes while the line is quiet, so it is used here without a crossing
    always_ff @(posedge link_clk_i) begin
        if (!rst_b_i) begin
            frame_q <= CNT_ZERO;
        end else if (frame_q == 4'h9) begin
            frame_q <= CNT_ZERO;
        end else if (frame_q != CNT_ZERO || (!serial_out_pin_o && !mode_q[MODE_SYNC_BIT])) begin
            frame_q <= frame_q + 4'h1;
        end
    end
    sequence s_rd(logic [ADDR_W-1:0] a);
        reg_req_i.rd && reg_req_i.addr == a;
    endsequence
    property p_mode_read;
        @(posedge core_clk_i) disable iff (!rst_b_i) s_rd(OFS_MODE) |=> reg_rdata_o == $past(mode_q);
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
    property p_mode_high;
        @(posedge core_clk_i) disable iff (!rst_b_i) s_rd(OFS_MODE) |-> ##1 reg_rdata_o[15:8] == 8'h00;
    endproperty
    a_mode_high: assert property (p_mode_high) else $error("mode upper bits set");
    property p_rx_width;
        @(posedge core_clk_i) disable iff (!rst_b_i) s_rd(OFS_RX_DATA) |=> reg_rdata_o[15:8] == 8'h00;
    endproperty
    a_rx_width: assert property (p_rx_width) else $error("receive data wider than a byte");
    property p_tx_wo;
        @(posedge core_clk_i) disable iff (!rst_b_i) s_rd(OFS_TX_DATA) |=> reg_rdata_o == REG_ZERO;
    endproperty
    a_tx_wo: assert property (p_tx_wo) else $error("transmit data readable");
    property p_hidden;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        reg_req_i.rd && !(reg_req_i.addr inside {4'h0, 4'h4, 4'h8, 4'hc}) |=> reg_rdata_o == REG_ZERO;
    endproperty
    a_hidden: assert property (p_hidden) else $error("unmapped read not zero");
    property p_rx_cap;
        @(posedge core_clk_i) disable iff (!rst_b_i) s_rd(OFS_STATUS) |=> reg_rdata_o[4:0] <= FIFO_FULL_COUNT;
    endproperty
    a_rx_cap: assert property (p_rx_cap) else $error("receive count above depth");
    property p_tx_cap;
        @(posedge core_clk_i) disable iff (!rst_b_i) s_rd(OFS_STATUS) |=> reg_rdata_o[9:5] <= FIFO_FULL_COUNT;
    endproperty
    a_tx_cap: assert property (p_tx_cap) else $error("transmit count above depth");
    property p_stop;
        @(posedge link_clk_i) disable iff (!rst_b_i) frame_q == 4'h9 |-> serial_out_pin_o == STOP_LEVEL;
    endproperty
    a_stop: assert property (p_stop) else $error("frame not closed by stop level");
endmodule
bind sfd_top sfd_top_sva i_sfd_top_sva (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .link_clk_i(link_clk_i),
    .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o),
    .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o)
);

/* tb/sfd_peer.sv */
// Serial peer: sends start-stop frames and collects those the data path sends
`timescale 1ns/10ps
module sfd_peer (
    input wire logic link_clk_i,
    input wire logic capture_en_i,
    input wire logic line_from_dut_i,
    output logic line_to_dut_o
);
    logic [7:0] got_q [$];
    logic [7:0] sh_q;
    int bit_n = 0;
    int low_run = 0;
    int max_low = 0;
    initial line_to_dut_o = 1'b1;
    // Falling edge drive gives the device a settled level at its rising edge
    task automatic send_byte(input logic [7:0] b);
        @(negedge link_clk_i);
        line_to_dut_o <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge link_clk_i);
            line_to_dut_o <= b[i];
        end
        @(negedge link_clk_i);
        line_to_dut_o <= 1'b1;
    endtask
    always @(negedge link_clk_i) begin
        low_run = (line_from_dut_i === 1'b0) ? low_run + 1 : 0;
        if (low_run > max_low) max_low = low_run;
        if (bit_n == 0) begin
            if (capture_en_i && line_from_dut_i === 1'b0) bit_n = 1;
        end else if (bit_n < 9) begin
            sh_q[bit_n-1] = line_from_dut_i;
            bit_n++;
        end else begin
            if (line_from_dut_i === 1'b1) got_q.push_back(sh_q);
            bit_n = 0;
        end
    end
endmodule

/* tb/sfd_top_bench.sv */
// Self-checking bench for the serial FIFO data path
`timescale 1ns/10ps
module sfd_top_bench;
    import sfd_pkg::*;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    sfd_reg_req_s req = '0;
    logic [REG_W-1:0] rdata;
    logic ser_in;
    logic ser_out;
    logic async_en = 1'b1;
    int mismatches = 0;
    int n_checks = 0;
    int n;
    logic [DATA_W-1:0] rxb [17];
    logic [DATA_W-1:0] txb [20];
    logic [REG_W-1:0] d;
    initial forever #10 core_clk = ~core_clk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    sfd_top i_sfd_top (.core_clk_i(core_clk), .rst_b_i(rst_b), .link_clk_i(link_clk),
        .reg_req_i(req), .reg_rdata_o(rdata), .serial_in_pin_i(ser_in), .serial_out_pin_o(ser_out));
    sfd_peer i_sfd_peer (.link_clk_i(link_clk), .capture_en_i(async_en),
        .line_from_dut_i(ser_out), .line_to_dut_o(ser_in));
    task automatic check(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // The bus tasks wr, idle and rd start in the time step of a rising edge and return in another; wait_st can start at any time and returns in one
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge core_clk);
    endtask
    task automatic idle();
        req <= '0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] v);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: REG_ZERO};
        @(posedge core_clk);
        req <= '0;
        #1;
        v = rdata;
        @(posedge core_clk);
    endtask
    // Polls status until the six bits from lsb match, bounded
    task automatic wait_st(input int lsb, input logic [5:0] want);
        logic ok;
        ok = 1'b0;
        repeat (10) @(posedge core_clk);
        for (int i = 0; i < 4000 && !ok; i++) begin
            rd(OFS_STATUS, d);
            ok = (d[lsb +: 6] === want);
        end
        if (!ok) begin
            mismatches++;
            $display("mismatch at %0t: status wait ran out", $time);
            tally_and_finish();
        end
    endtask
    initial begin
        for (int i = 0; i < 17; i++) rxb[i] = 8'(195 + 37 * i);
        for (int i = 0; i < 20; i++) txb[i] = 8'(7 + 29 * i);
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(OFS_MODE, d);
        check(d, MODE_RESET);
        // Upper byte written as zero; bit 7 stays clear so no stray sync byte is received
        wr(OFS_MODE, 16'h007f);
        rd(OFS_MODE, d);
        check(d, 16'h007f);
        wr(OFS_MODE, MODE_RESET);
        rd(OFS_TX_DATA, d);
        check(d, REG_ZERO);
        rd(4'h2, d);
        check(d, REG_ZERO);
        rd(OFS_RX_DATA, d);
        // Seventeen frames back to back: the last one meets a full FIFO
        for (int i = 0; i < 17; i++) i_sfd_peer.send_byte(rxb[i]);
        wait_st(0, 6'h10);
        repeat (20) @(posedge core_clk);
        wr(OFS_RX_DATA, 16'h00ee);
        rd(OFS_STATUS, d);
        check(16'(d[4:0]), 16'h0010);
        for (int i = 0; i < 16; i++) begin
            rd(OFS_RX_DATA, d);
            check(d, {8'h00, rxb[i]});
        end
        rd(OFS_STATUS, d);
        check(16'(d[4:0]), 16'h0000);
        for (int i = 0; i < 20; i++) wr(OFS_TX_DATA, {8'h00, txb[i]});
        idle();
        wait_st(5, 6'h00);
        repeat (40) @(posedge core_clk);
        n = i_sfd_peer.got_q.size();
        // The line may drain one or two bytes while the writes go in
        check(16'(n >= 16 && n <= 18), 16'h0001);
        for (int i = 0; i < n && i < 20; i++) begin
            check({8'h00, i_sfd_peer.got_q[i]}, {8'h00, txb[i]});
        end
        async_en <= 1'b0;
        i_sfd_peer.max_low = 0;
        wr(OFS_MODE, 16'h0080);
        rd(OFS_MODE, d);
        check(d, 16'h0080);
        wr(OFS_TX_DATA, 16'h0000);
        idle();
        wait_st(5, 6'h00);
        repeat (40) @(posedge core_clk);
        check(16'(i_sfd_peer.max_low), 16'h0008);
        tally_and_finish();
    end
endmodule
